// ===== core/blcr_map.svh
/*
 * register offsets, field positions and reset values of the sink current
 * and first user settings registers.
 * assumes inclusion by bare name from the register bank module.
 */
`ifndef BLCR_MAP_SVH
`define BLCR_MAP_SVH

`define BLCR_OFS_SINK_CURRENT 8'h02
`define BLCR_OFS_USER_ONE 8'h04
`define BLCR_RST_SINK_CURRENT 16'h0fff
`define BLCR_RST_USER_ONE 16'h08a3
`define BLCR_LEVEL_MSB 11
`define BLCR_LEVEL_LSB 0
`define BLCR_PSEUDO_BIT 14
`define BLCR_MODRATE_MSB 13
`define BLCR_MODRATE_LSB 12
`define BLCR_RANGE_MSB 11
`define BLCR_RANGE_LSB 10
`define BLCR_SRC_MSB 9
`define BLCR_SRC_LSB 8

`endif

// ===== core/blcr_pkg.sv
/*
 * types shared by the configuration register bank.
 * assumes blcr_map.svh is on the include path.
 */
package blcr_pkg;
    typedef logic [15:0] blcr_word_t;

    // modulation rate codes: 200 hz, 500 hz, 800 hz, 1.2 khz
    typedef enum logic [1:0] {
        BLCR_MOD_200HZ = 2'b00,
        BLCR_MOD_500HZ = 2'b01,
        BLCR_MOD_800HZ = 2'b10,
        BLCR_MOD_1K2HZ = 2'b11
    } blcr_modrate_e;

    // spread range codes: 3.3, 4.3, 5.3, 7.2 percent
    typedef enum logic [1:0] {
        BLCR_RANGE_3P3 = 2'b00,
        BLCR_RANGE_4P3 = 2'b01,
        BLCR_RANGE_5P3 = 2'b10,
        BLCR_RANGE_7P2 = 2'b11
    } blcr_range_e;

    typedef enum logic [1:0] {
        BLCR_SRC_PWM_PIN = 2'b00,
        BLCR_SRC_RSVD1 = 2'b01,
        BLCR_SRC_REGISTER = 2'b10,
        BLCR_SRC_RSVD3 = 2'b11
    } blcr_src_e;
endpackage

// ===== core/blcr_reg16.sv
/*
 * one 16-bit read/write storage register with a reset value.
 * assumes write strobe and data from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module blcr_reg16 #(
    parameter logic [15:0] RESET_VAL = 16'h0000
) (
    // clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // write side
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    // stored value
    output logic [15:0] q
);
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= RESET_VAL;
        end else if (ce && wr_en) begin
            q <= wr_data;
        end
    end
endmodule // blcr_reg16

`default_nettype wire

// ===== core/blcr_regs.sv
/*
 * configuration register bank: sink current level and first user settings,
 * reached through a word-wide register port fed by the serial interface.
 * assumes the serial interface decodes frames on clk and presents one-cycle
 * read and write strobes with a byte offset; rst is synchronous.
 */
`timescale 1ns/1ps
`default_nettype none

`include "blcr_map.svh"

// Functional notes
// RULE1 - the sink current register is at offset 0x02, 16 bits, reset 0x0fff.
// RULE2 - bits 11..0 hold the read/write current level for all sinks, reset all ones.
// RULE3 - bits 15..12 of the sink current register are reserved read/write, reset zero.
// RULE4 - the first user settings register is at offset 0x04, 16 bits, reset 0x08a3.
// RULE5 - bit 15 of the user settings register is reserved read/write, reset zero.
// RULE6 - bit 14 enables pseudo-random spread modulation, reset zero.
// RULE7 - bits 13..12 pick modulation rate 200, 500, 800 hz or 1.2 khz, reset code 0.
// RULE8 - bits 11..10 pick spread range 3.3, 4.3, 5.3 or 7.2 percent, reset code 2.
// RULE9 - bits 9..8 pick brightness from the pwm pin (0) or register (2), reset 0.
// RULE10 - the host must not write source codes 1 or 3 and should keep reserved bits.
module blcr_regs
    import blcr_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // configuration outputs
    output logic [11:0] sink_current_level,
    output logic spread_pseudo_en,
    output blcr_modrate_e spread_modulation_rate,
    output blcr_range_e boost_switching_oscillator_range,
    output blcr_src_e brightness_source_select,
    output logic use_brightness_setting_register
);

    // offset 0x04 needs at least three address bits
    if (ADDR_W < 3) begin : g_addr_w_check
        $error("blcr_regs: ADDR_W too small for offset 0x04");
    end

    ////////////////////////////////////////////////////////////////////////

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        addr_hit = (a == ADDR_W'(ofs));
    endfunction

    wire logic hit_cur;
    wire logic hit_usr;
    wire logic wr_cur;
    wire logic wr_usr;
    wire blcr_word_t cur_q;
    wire blcr_word_t usr_q;
    wire blcr_word_t rd_mux;

    // RULE1 offset decode
    assign hit_cur = addr_hit(reg_addr, `BLCR_OFS_SINK_CURRENT);
    // RULE4 offset decode
    assign hit_usr = addr_hit(reg_addr, `BLCR_OFS_USER_ONE);
    assign wr_cur = reg_wr && hit_cur;
    assign wr_usr = reg_wr && hit_usr;

    // unmapped offsets read as zero; writes there are dropped
    assign rd_mux = hit_cur ? cur_q : (hit_usr ? usr_q : 16'h0000);

    ////////////////////////////////////////////////////////////////////////

    // RULE2 level storage, reset all ones
    // RULE3 reserved nibble kept as written
    blcr_reg16 #(
        .RESET_VAL(`BLCR_RST_SINK_CURRENT)
    ) u_cur (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .wr_en(wr_cur),
        .wr_data(reg_wdata),
        .q(cur_q)
    );

    // RULE5 reserved bit kept as written
    // RULE10 reserved source codes stored as is, host must avoid them
    blcr_reg16 #(
        .RESET_VAL(`BLCR_RST_USER_ONE)
    ) u_usr (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .wr_en(wr_usr),
        .wr_data(reg_wdata),
        .q(usr_q)
    );

    ////////////////////////////////////////////////////////////////////////

    // outputs registered so the datapath sees clean flip-flop levels;
    // they trail the storage by one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
            sink_current_level <= 12'hfff;
            spread_pseudo_en <= 1'b0;
            spread_modulation_rate <= BLCR_MOD_200HZ;
            boost_switching_oscillator_range <= BLCR_RANGE_5P3;
            brightness_source_select <= BLCR_SRC_PWM_PIN;
            use_brightness_setting_register <= 1'b0;
        end else if (ce) begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rd_mux;
            end
            // RULE2 common sink level
            sink_current_level <= cur_q[`BLCR_LEVEL_MSB:`BLCR_LEVEL_LSB];
            // RULE6 pseudo-random enable
            spread_pseudo_en <= usr_q[`BLCR_PSEUDO_BIT];
            // RULE7 modulation rate
            spread_modulation_rate <= blcr_modrate_e'(usr_q[`BLCR_MODRATE_MSB:`BLCR_MODRATE_LSB]);
            // RULE8 spread range
            boost_switching_oscillator_range <=
                blcr_range_e'(usr_q[`BLCR_RANGE_MSB:`BLCR_RANGE_LSB]);
            // RULE9 brightness source
            brightness_source_select <= blcr_src_e'(usr_q[`BLCR_SRC_MSB:`BLCR_SRC_LSB]);
            // reserved codes fall back to the pwm pin rather than guess
            use_brightness_setting_register <=
                (usr_q[`BLCR_SRC_MSB:`BLCR_SRC_LSB] == BLCR_SRC_REGISTER);
        end
    end

    ////////////////////////////////////////////////////////////////////////

    property p_cur_reset;
        @(posedge clk) disable iff (rst) $fell(rst) |-> cur_q == `BLCR_RST_SINK_CURRENT;
    endproperty
    a_cur_reset: assert property (p_cur_reset) else $error("sink current reset wrong"); // RULE1

    property p_level_follow;
        @(posedge clk) disable iff (rst)
            ce && wr_cur ##1 ce |=> sink_current_level == $past(reg_wdata[11:0], 2);
    endproperty
    a_level_follow: assert property (p_level_follow) else $error("level not applied"); // RULE2

    property p_rsvd_cur;
        @(posedge clk) disable iff (rst)
            ce && wr_cur |=> cur_q[15:12] == $past(reg_wdata[15:12]);
    endproperty
    a_rsvd_cur: assert property (p_rsvd_cur) else $error("reserved nibble lost"); // RULE3

    property p_usr_reset;
        @(posedge clk) disable iff (rst) $fell(rst) |-> usr_q == `BLCR_RST_USER_ONE;
    endproperty
    a_usr_reset: assert property (p_usr_reset) else $error("user settings reset wrong"); // RULE4

    property p_rsvd_usr;
        @(posedge clk) disable iff (rst)
            ce && wr_usr |=> usr_q[15] == $past(reg_wdata[15]);
    endproperty
    a_rsvd_usr: assert property (p_rsvd_usr) else $error("reserved bit lost"); // RULE5

    property p_pseudo;
        @(posedge clk) disable iff (rst)
            ce && wr_usr ##1 ce |=> spread_pseudo_en == $past(reg_wdata[14], 2);
    endproperty
    a_pseudo: assert property (p_pseudo) else $error("pseudo enable wrong"); // RULE6

    property p_modrate;
        @(posedge clk) disable iff (rst)
            ce && wr_usr ##1 ce |=> spread_modulation_rate == $past(reg_wdata[13:12], 2);
    endproperty
    a_modrate: assert property (p_modrate) else $error("modulation rate wrong"); // RULE7

    property p_range;
        @(posedge clk) disable iff (rst)
            ce && wr_usr ##1 ce |=> boost_switching_oscillator_range == $past(reg_wdata[11:10], 2);
    endproperty
    a_range: assert property (p_range) else $error("spread range wrong"); // RULE8

    property p_src;
        @(posedge clk) disable iff (rst)
            ce && wr_usr ##1 ce |=>
                use_brightness_setting_register == ($past(reg_wdata[9:8], 2) == 2'b10);
    endproperty
    a_src: assert property (p_src) else $error("brightness source wrong"); // RULE9

    property p_readback;
        @(posedge clk) disable iff (rst)
            ce && reg_rd && hit_usr && !reg_wr |=> reg_rvalid && reg_rdata == $past(usr_q);
    endproperty
    a_readback: assert property (p_readback) else $error("readback wrong"); // RULE4

    property p_out_reset;
        @(posedge clk) disable iff (rst)
            $fell(rst) |-> {4'h0, sink_current_level} == `BLCR_RST_SINK_CURRENT
                && boost_switching_oscillator_range == BLCR_RANGE_5P3
                && brightness_source_select == BLCR_SRC_PWM_PIN;
    endproperty
    a_out_reset: assert property (p_out_reset) else $error("output reset wrong"); // RULE8

    property p_cur_hold;
        @(posedge clk) disable iff (rst)
            !(ce && wr_cur) |=> cur_q == $past(cur_q);
    endproperty
    a_cur_hold: assert property (p_cur_hold) else $error("sink current moved"); // RULE1

    property p_usr_hold;
        @(posedge clk) disable iff (rst)
            !(ce && wr_usr) |=> usr_q == $past(usr_q);
    endproperty
    a_usr_hold: assert property (p_usr_hold) else $error("user settings moved"); // RULE4

    property p_rvalid_only_read;
        @(posedge clk) disable iff (rst)
            ce && !reg_rd |=> !reg_rvalid;
    endproperty
    a_rvalid_only_read: assert property (p_rvalid_only_read) else $error("stray valid"); // RULE1

endmodule // blcr_regs

`default_nettype wire

// ===== tb/blcr_host_model.sv
/*
 * host side model: drives the word-wide register port the way the
 * serial interface front end does, one-cycle strobes on clk.
 * assumes the bench calls its tasks from one process at a time.
 */
`timescale 1ns/1ps
`default_nettype none

module blcr_host_model (
    // clock
    input wire logic clk,
    // register port
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reserved source codes withheld
    task automatic write_word(input logic [7:0] addr, input logic [15:0] data);
        if (addr == 8'h04 && data[8]) begin
            return;
        end
        @(posedge clk);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        // released lines show the inverse, so a stale value cannot pass
        reg_addr <= ~addr;
        reg_wdata <= ~data;
    endtask

    task automatic read_word(input logic [7:0] addr, output logic [15:0] data,
                             output logic valid);
        @(posedge clk);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~addr;
        // valid stands one cycle only: take it settled, just after the taking edge
        #1;
        valid = reg_rvalid;
        data = reg_rdata;
    endtask
endmodule // blcr_host_model

`default_nettype wire

// ===== tb/testbench.sv
/*
 * self-checking bench for the configuration register bank.
 * assumes the core files and the host model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import blcr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    wire logic [7:0] reg_addr;
    wire logic reg_wr;
    wire logic reg_rd;
    wire logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    logic [11:0] level;
    logic pseudo;
    blcr_modrate_e rate;
    blcr_range_e range;
    blcr_src_e src;
    logic use_reg;
    int mismatches = 0;
    int compares = 0;
    logic [15:0] w;

    always #12.5 clk = ~clk;

    blcr_regs dut_u (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .sink_current_level(level), .spread_pseudo_en(pseudo), .spread_modulation_rate(rate),
        .boost_switching_oscillator_range(range), .brightness_source_select(src),
        .use_brightness_setting_register(use_reg));

    blcr_host_model host_u (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd_check(input logic [7:0] addr, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        host_u.read_word(addr, d, v);
        check({15'h0000, v}, 16'h0001);
        check(d, exp);
    endtask

    // use flag is high only for source code 2
    task automatic cfg_check(input logic [15:0] exp);
        check({8'h00, pseudo, rate, range, src, use_reg},
            {8'h00, exp[14:8], exp[9:8] == 2'b10});
    endtask

    task automatic complete_run;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        check({4'h0, level}, 16'h0fff);
        cfg_check(16'h08a3);
        rd_check(8'h02, 16'h0fff);
        rd_check(8'h04, 16'h08a3);
        for (int i = 0; i < 4; i++) begin
            w = {1'b0, i[0], i[1:0], 2'(3 - i), i[0] ? 2'b00 : 2'b10, 8'ha3};
            host_u.write_word(8'h04, w);
            rd_check(8'h04, w);
            cfg_check(w);
        end
        for (int k = 0; k < 2; k++) begin
            w = k ? 16'h0abc : 16'h0000;
            host_u.write_word(8'h02, w);
            rd_check(8'h02, w);
            check({4'h0, level}, w);
        end
        // unmapped offset: write dropped, read gives zero
        host_u.write_word(8'h06, 16'h5555);
        rd_check(8'h06, 16'h0000);
        rd_check(8'h02, 16'h0abc);
        // clock enable low freezes the store
        @(posedge clk);
        ce <= 1'b0;
        host_u.write_word(8'h02, 16'h0123);
        ce <= 1'b1;
        rd_check(8'h02, 16'h0abc);
        check({4'h0, level}, 16'h0abc);
        // second reset in mid-run restores both words
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_check(8'h02, 16'h0fff);
        rd_check(8'h04, 16'h08a3);
        check({4'h0, level}, 16'h0fff);
        cfg_check(16'h08a3);
        complete_run();
    end

    // tests take about fifty cycles
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        complete_run();
    end
endmodule // testbench

`default_nettype wire
